// *** verilog/sllsu_pkg.sv ***
// package: constants for the serial link latency setup controller
package sllsu_pkg;
   // device register addresses
   localparam logic [15:0] SLLSU_ADDR_SYNC_CTRL = 16'h003A;
   localparam logic [15:0] SLLSU_ADDR_LINK_CTRL = 16'h0300;
   localparam logic [15:0] SLLSU_ADDR_SUBCLASS = 16'h0301;
   localparam logic [15:0] SLLSU_ADDR_LAT0 = 16'h0302;
   localparam logic [15:0] SLLSU_ADDR_LAT1 = 16'h0303;
   // sync control values
   localparam logic [7:0] SLLSU_SYNC_ONESHOT = 8'h01;
   localparam logic [7:0] SLLSU_SYNC_ENABLE = 8'h81;
   localparam logic [7:0] SLLSU_SYNC_ARM = 8'hC1;
   // link control field positions and enable values
   localparam int SLLSU_LC_CHECKSUM = 6;
   localparam int SLLSU_LC_DUAL = 3;
   localparam int SLLSU_LC_STATUS = 2;
   localparam logic [1:0] SLLSU_EN_DUAL = 2'h3;
   localparam logic [1:0] SLLSU_EN_SINGLE = 2'h1;
   // power-down values
   localparam logic [3:0] SLLSU_PD_M1_SINGLE = 4'h7;
   localparam logic [3:0] SLLSU_PD_M1_DUAL = 4'h5;
   localparam logic [3:0] SLLSU_PD_M2_SINGLE = 4'h3;
   localparam logic [3:0] SLLSU_PD_NONE = 4'h0;
   localparam logic [7:0] SLLSU_PDCLK_OFF = 8'h40;
   localparam logic [7:0] SLLSU_PDCLK_ON = 8'h00;
   // lane rate thresholds in Mbps
   localparam logic [15:0] SLLSU_RATE_LOW_MAX = 16'h0C1C;
   localparam logic [15:0] SLLSU_RATE_MID_MAX = 16'h1838;
   // insertion loss threshold in tenths of dB, delay variance limit
   localparam logic [7:0] SLLSU_LOSS_LOWPWR_MAX = 8'h78;
   localparam logic [7:0] SLLSU_VAR_MAX = 8'h0A;
   // own software registers
   localparam logic [3:0] SLLSU_R_CFG = 4'h0;
   localparam logic [3:0] SLLSU_R_RATE = 4'h1;
   localparam logic [3:0] SLLSU_R_DELAY = 4'h2;
   localparam logic [3:0] SLLSU_R_CMD = 4'h3;
   localparam logic [3:0] SLLSU_R_STATUS = 4'h4;
   localparam logic [3:0] SLLSU_R_PHY = 4'h5;
   localparam logic [3:0] SLLSU_R_LMFC = 4'h6;
   localparam logic [3:0] SLLSU_R_LAT = 4'h7;
   localparam logic [3:0] SLLSU_R_LATMM = 4'h8;
   localparam logic [31:0] SLLSU_CFG_RESET = 32'h0000_0000;
   typedef enum logic [1:0] {SLLSU_KN_IDLE, SLLSU_KN_RUN} sllsu_dummy_t;
endpackage

// *** verilog/sllsu_regport.sv ***
// device register port master: one write or read at a time
`timescale 1ns/100ps
module sllsu_regport
   import sllsu_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire logic is_read,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   output logic busy,
   output logic done,
   output logic [7:0] rdata,
   output logic [15:0] dev_addr,
   output logic [7:0] dev_wdata,
   output logic dev_wr,
   output logic dev_rd,
   input wire logic [7:0] dev_rdata
);
   logic pend;
   logic next_pend;
   logic next_done;
   logic [7:0] next_rdata;
   logic [15:0] next_dev_addr;
   logic [7:0] next_dev_wdata;
   logic next_dev_wr;
   logic next_dev_rd;

   // read data stand one cycle after the read strobe
   always_comb begin
      next_pend = 1'b0;
      next_done = 1'b0;
      next_rdata = rdata;
      next_dev_addr = dev_addr;
      next_dev_wdata = dev_wdata;
      next_dev_wr = 1'b0;
      next_dev_rd = 1'b0;
      if (start && !busy) begin
         next_dev_addr = addr;
         next_dev_wdata = wdata;
         next_dev_wr = !is_read;
         next_dev_rd = is_read;
         next_pend = 1'b1;
      end else if (pend && dev_rd) begin
         next_pend = 1'b1;
      end else if (pend) begin
         next_done = 1'b1;
         next_rdata = dev_rdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pend <= 1'b0;
         done <= 1'b0;
         rdata <= 8'h00;
         dev_addr <= 16'h0000;
         dev_wdata <= 8'h00;
         dev_wr <= 1'b0;
         dev_rd <= 1'b0;
      end else begin
         pend <= next_pend;
         done <= next_done;
         rdata <= next_rdata;
         dev_addr <= next_dev_addr;
         dev_wdata <= next_dev_wdata;
         dev_wr <= next_dev_wr;
         dev_rd <= next_dev_rd;
      end
   end

   assign busy = pend;
endmodule

// *** verilog/sllsu_host.sv ***
// host controller: link setup values, one-shot sync and latency readback
`timescale 1ns/100ps
// How it works
// - power-down mask from converter count, link mode
// - pair clock off 0x40 when pair down
// - clock recovery settings chosen by lane rate
// - low-power equalizer below 12 dB loss
// - factor is 4/F, per-multiframe K/factor
// - factor per mode; modes 0,4,9 need K32
// - variance is max+1 minus min-1, limit 10
// - delay setting modulo K or per-multiframe
// - same delay, variance on every link
// - min floor fixed, max ceiling with variable
// - add per-multiframe to values near zero
// - pool readbacks over repeated runs
// - subclass, 0x01, 0x81, 0xC1, then enable links
// - SYSREF edge before links enabled in subclass 1
// - link control bit layout and enable values
// - settings must match the transmitter
module sllsu_host
   import sllsu_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic [3:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   output logic [15:0] DEV_ADDR,
   output logic [7:0] DEV_WDATA,
   output logic DEV_WR,
   output logic DEV_RD,
   input wire logic [7:0] DEV_RDATA,
   output logic SYSREF_PULSE
);
   typedef enum logic [3:0] {
      SLLSU_IDLE, SLLSU_SUB, SLLSU_S01, SLLSU_S81, SLLSU_SC1, SLLSU_SREF,
      SLLSU_LINK, SLLSU_RL0, SLLSU_RL1, SLLSU_WAIT
   } sllsu_state_t;

   // cfg: [3:0] mode, [4] K32, [5] dual, [6] checksum, [7] subclass,
   // [15:8] loss tenths dB, [16] status link
   logic [31:0] cfg;
   logic [15:0] rate;
   logic [15:0] delays;
   logic [31:0] rd_mux;
   sllsu_state_t state;
   sllsu_state_t ret;
   logic [7:0] lat0;
   logic [7:0] lat1;
   logic [7:0] lat_min;
   logic [7:0] lat_max;
   logic seen;
   logic cfg_err;
   logic next_sysref;
   logic [31:0] next_cfg;
   logic [15:0] next_rate;
   logic [15:0] next_delays;
   sllsu_state_t next_state;
   sllsu_state_t next_ret;
   logic [7:0] next_lat0;
   logic [7:0] next_lat1;
   logic [7:0] next_lat_min;
   logic [7:0] next_lat_max;
   logic next_seen;
   logic [31:0] next_rdata;
   logic rp_start;
   logic rp_read;
   logic [15:0] rp_addr;
   logic [7:0] rp_wdata;
   logic rp_done;
   logic [7:0] rp_rdata;

   function automatic logic [2:0] factor(input logic [3:0] mode);
      case (mode)
         4'd0, 4'd4, 4'd9: factor = 3'd4;
         4'd3, 4'd7: factor = 3'd1;
         default: factor = 3'd2;
      endcase
   endfunction

   // values below half a multiframe rolled over the edge
   function automatic logic [7:0] remap(input logic [7:0] v, input logic [5:0] pm);
      remap = (v < {2'd0, pm >> 1}) ? v + {2'd0, pm} : v;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // derived setup values
   logic [3:0] mode;
   logic [2:0] fac;
   logic [5:0] kval;
   logic [5:0] pcmf;
   logic [3:0] pd_mask;
   logic [7:0] pd_clk;
   logic [2:0] cdr;
   logic eq_low;
   logic [7:0] dmin;
   logic [7:0] dmax;
   logic [7:0] var_set;
   logic [7:0] del_set;
   logic [7:0] lat_adj0;
   logic [7:0] lat_adj1;
   logic [7:0] link_ctrl;

   always_comb begin
      mode = cfg[3:0];
      fac = factor(mode);
      kval = cfg[4] ? 6'd32 : 6'd16;
      pcmf = kval / {3'd0, fac};
      // converter count follows mode
      if (mode >= 4'd9)
         pd_mask = cfg[5] ? SLLSU_PD_M1_DUAL : SLLSU_PD_M1_SINGLE;
      else if (mode >= 4'd4 && !cfg[5])
         pd_mask = SLLSU_PD_M2_SINGLE;
      else
         pd_mask = SLLSU_PD_NONE;
      // mask msb is converter 0, so the second pair sits in bits 1:0
      pd_clk = (pd_mask[1] && pd_mask[0]) ? SLLSU_PDCLK_OFF : SLLSU_PDCLK_ON;
      // {oversample, divider}; half rate goes with divider 0
      if (rate <= SLLSU_RATE_LOW_MAX)
         cdr = 3'h6;
      else if (rate <= SLLSU_RATE_MID_MAX)
         cdr = 3'h1;
      else
         cdr = 3'h0;
      eq_low = cfg[15:8] < SLLSU_LOSS_LOWPWR_MAX;
      // known delays (in processing clocks) or pooled readback
      dmin = seen ? lat_min : delays[7:0];
      dmax = seen ? lat_max : delays[15:8];
      var_set = (dmax + 8'd1) - (dmin - 8'd1);
      if (cfg[7])
         del_set = 8'((16'(dmin - 8'd1) * 16'(fac)) % 16'(kval));
      else
         del_set = 8'((dmin - 8'd1) % {2'd0, pcmf});
      cfg_err = (var_set > SLLSU_VAR_MAX) || (fac == 3'd4 && !cfg[4]);
      link_ctrl = 8'h00;
      link_ctrl[SLLSU_LC_CHECKSUM] = cfg[6];
      link_ctrl[SLLSU_LC_DUAL] = cfg[5];
      link_ctrl[SLLSU_LC_STATUS] = cfg[16];
      link_ctrl[1:0] = cfg[5] ? SLLSU_EN_DUAL : SLLSU_EN_SINGLE;
      // rollover remap near zero
      lat_adj0 = remap(lat0, pcmf);
      // link 1 value as it arrives from the port
      lat_adj1 = remap(rp_rdata, pcmf);
   end

   ////////////////////////////////////////////////////////////////////////
   // sequencer
   always_comb begin
      next_state = state;
      next_ret = ret;
      next_lat0 = lat0;
      next_lat1 = lat1;
      next_lat_min = lat_min;
      next_lat_max = lat_max;
      next_seen = seen;
      next_sysref = 1'b0;
      rp_start = 1'b0;
      rp_read = 1'b0;
      rp_addr = SLLSU_ADDR_SUBCLASS;
      rp_wdata = 8'h00;
      case (state)
         SLLSU_IDLE: begin
            if (WR && ADDR == SLLSU_R_CMD && WDATA[0])
               next_state = SLLSU_SUB;
            if (WR && ADDR == SLLSU_R_CMD && WDATA[1])
               next_seen = 1'b0;
         end
         SLLSU_SUB: begin
            rp_start = 1'b1;
            rp_wdata = {7'd0, cfg[7]};
            next_state = SLLSU_WAIT;
            next_ret = SLLSU_S01;
         end
         SLLSU_S01, SLLSU_S81, SLLSU_SC1: begin
            rp_start = 1'b1;
            rp_addr = SLLSU_ADDR_SYNC_CTRL;
            rp_wdata = state == SLLSU_S01 ? SLLSU_SYNC_ONESHOT :
                       state == SLLSU_S81 ? SLLSU_SYNC_ENABLE : SLLSU_SYNC_ARM;
            next_state = SLLSU_WAIT;
            next_ret = state == SLLSU_S01 ? SLLSU_S81 : state == SLLSU_S81 ? SLLSU_SC1 : SLLSU_SREF;
         end
         SLLSU_SREF: begin
            next_sysref = cfg[7];
            next_state = SLLSU_LINK;
         end
         SLLSU_LINK: begin
            rp_start = 1'b1;
            rp_addr = SLLSU_ADDR_LINK_CTRL;
            rp_wdata = link_ctrl;
            next_state = SLLSU_WAIT;
            next_ret = SLLSU_RL0;
         end
         SLLSU_RL0, SLLSU_RL1: begin
            rp_start = 1'b1;
            rp_read = 1'b1;
            rp_addr = state == SLLSU_RL0 ? SLLSU_ADDR_LAT0 : SLLSU_ADDR_LAT1;
            next_state = SLLSU_WAIT;
            next_ret = state == SLLSU_RL0 ? SLLSU_RL1 : SLLSU_IDLE;
         end
         SLLSU_WAIT: begin
            if (rp_done) begin
               next_state = ret;
               if (ret == SLLSU_RL1)
                  next_lat0 = rp_rdata;
               if (ret == SLLSU_IDLE && state == SLLSU_WAIT) begin
                  next_lat1 = rp_rdata;
                  // both links pooled across runs
                  next_lat_min = (lat_adj0 < lat_adj1) ? lat_adj0 : lat_adj1;
                  next_lat_max = (lat_adj0 > lat_adj1) ? lat_adj0 : lat_adj1;
                  if (seen && lat_min < next_lat_min)
                     next_lat_min = lat_min;
                  if (seen && lat_max > next_lat_max)
                     next_lat_max = lat_max;
                  next_seen = 1'b1;
               end
            end
         end
         default: next_state = SLLSU_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // software registers
   always_comb begin
      next_cfg = cfg;
      next_rate = rate;
      next_delays = delays;
      if (WR && state == SLLSU_IDLE) begin
         case (ADDR)
            SLLSU_R_CFG: next_cfg = WDATA;
            SLLSU_R_RATE: next_rate = WDATA[15:0];
            SLLSU_R_DELAY: next_delays = WDATA[15:0];
            default: next_cfg = cfg;
         endcase
      end
      case (ADDR)
         SLLSU_R_CFG: rd_mux = cfg;
         SLLSU_R_RATE: rd_mux = {16'd0, rate};
         SLLSU_R_DELAY: rd_mux = {16'd0, delays};
         SLLSU_R_STATUS: rd_mux = {26'd0, seen, cfg_err, 3'd0, state != SLLSU_IDLE};
         SLLSU_R_PHY: rd_mux = {16'd0, pd_clk, eq_low, cdr, pd_mask};
         SLLSU_R_LMFC: rd_mux = {16'd0, var_set, del_set};
         SLLSU_R_LAT: rd_mux = {16'd0, lat1, lat0};
         SLLSU_R_LATMM: rd_mux = {16'd0, lat_max, lat_min};
         default: rd_mux = 32'h0000_0000;
      endcase
      next_rdata = RD ? rd_mux : 32'h0000_0000;
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         cfg <= SLLSU_CFG_RESET;
         rate <= 16'h0000;
         delays <= 16'h0000;
         state <= SLLSU_IDLE;
         ret <= SLLSU_IDLE;
         lat0 <= 8'h00;
         lat1 <= 8'h00;
         lat_min <= 8'h00;
         lat_max <= 8'h00;
         seen <= 1'b0;
         RDATA <= 32'h0000_0000;
         SYSREF_PULSE <= 1'b0;
      end else begin
         cfg <= next_cfg;
         rate <= next_rate;
         delays <= next_delays;
         state <= next_state;
         ret <= next_ret;
         lat0 <= next_lat0;
         lat1 <= next_lat1;
         lat_min <= next_lat_min;
         lat_max <= next_lat_max;
         seen <= next_seen;
         RDATA <= next_rdata;
         SYSREF_PULSE <= next_sysref;
      end
   end

   sllsu_regport u_port (
      .clk(SYS_CLK),
      .rst(RST),
      .start(rp_start),
      .is_read(rp_read),
      .addr(rp_addr),
      .wdata(rp_wdata),
      .busy(),
      .done(rp_done),
      .rdata(rp_rdata),
      .dev_addr(DEV_ADDR),
      .dev_wdata(DEV_WDATA),
      .dev_wr(DEV_WR),
      .dev_rd(DEV_RD),
      .dev_rdata(DEV_RDATA)
   );
endmodule

// *** testbench/sllsu_host_asserts.sv ***
// checker: port-level properties of the link setup controller
`timescale 1ns/100ps
module sllsu_host_asserts
   import sllsu_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic [3:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [31:0] RDATA,
   input wire logic [15:0] DEV_ADDR,
   input wire logic [7:0] DEV_WDATA,
   input wire logic DEV_WR,
   input wire logic DEV_RD,
   input wire logic [7:0] DEV_RDATA,
   input wire logic SYSREF_PULSE
);
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (RST);
   logic sub1, next_sub1, seen, next_seen;
   logic [7:0] last, next_last;
   always_comb begin
      next_sub1 = sub1;
      next_last = last;
      next_seen = seen | SYSREF_PULSE;
      if (DEV_WR && DEV_ADDR == SLLSU_ADDR_SUBCLASS) begin
         next_sub1 = DEV_WDATA[0];
      end
      if (DEV_WR && DEV_ADDR == SLLSU_ADDR_SYNC_CTRL) begin
         next_last = DEV_WDATA;
         next_seen = 1'b0;
      end
   end
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         sub1 <= 1'b0;
         last <= 8'h00;
         seen <= 1'b0;
      end else begin
         sub1 <= next_sub1;
         last <= next_last;
         seen <= next_seen;
      end
   end
   wire sync_wr = DEV_WR && DEV_ADDR == SLLSU_ADDR_SYNC_CTRL;
   wire link_wr = DEV_WR && DEV_ADDR == SLLSU_ADDR_LINK_CTRL;
   property p_rdata_idle;
      !RD |=> RDATA == 32'h0000_0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
   property p_access_gap;
      (DEV_WR || DEV_RD) |=> !(DEV_WR || DEV_RD);
   endproperty
   a_access_gap: assert property (p_access_gap) else $error("device accesses adjacent");
   property p_enable_step;
      sync_wr && DEV_WDATA == SLLSU_SYNC_ENABLE |-> last == SLLSU_SYNC_ONESHOT;
   endproperty
   a_enable_step: assert property (p_enable_step) else $error("enable before one-shot");
   property p_arm_step;
      sync_wr && DEV_WDATA == SLLSU_SYNC_ARM |-> last == SLLSU_SYNC_ENABLE;
   endproperty
   a_arm_step: assert property (p_arm_step) else $error("arm before enable");
   property p_ref_armed;
      SYSREF_PULSE |-> sub1 && last == SLLSU_SYNC_ARM;
   endproperty
   a_ref_armed: assert property (p_ref_armed) else $error("stray reference pulse");
   property p_link_after_ref;
      link_wr |-> last == SLLSU_SYNC_ARM && (seen || !sub1);
   endproperty
   a_link_after_ref: assert property (p_link_after_ref) else $error("links enabled early");
   property p_ro_untouched;
      DEV_WR |-> DEV_ADDR != SLLSU_ADDR_LAT0 && DEV_ADDR != SLLSU_ADDR_LAT1;
   endproperty
   a_ro_untouched: assert property (p_ro_untouched) else $error("latency register written");
   property p_lc_enable;
      link_wr |-> DEV_WDATA[1:0] == (DEV_WDATA[3] ? SLLSU_EN_DUAL : SLLSU_EN_SINGLE);
   endproperty
   a_lc_enable: assert property (p_lc_enable) else $error("link enable field");
   property p_lat_pair;
      DEV_RD && DEV_ADDR == SLLSU_ADDR_LAT0 |-> ##[1:8] DEV_RD && DEV_ADDR == SLLSU_ADDR_LAT1;
   endproperty
   a_lat_pair: assert property (p_lat_pair) else $error("second latency not read");
   c_link: cover property (link_wr);
   c_ref: cover property (SYSREF_PULSE);
   c_lat: cover property (DEV_RD && DEV_ADDR == SLLSU_ADDR_LAT1);
endmodule

// *** testbench/sllsu_dev_model.sv ***
// model: receiver register set behind the device port
`timescale 1ns/100ps
module sllsu_dev_model
   import sllsu_pkg::*;
#(
   parameter logic [7:0] LAT0 = 8'h06,
   parameter logic [7:0] LAT1 = 8'h0E
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [15:0] dev_addr,
   input wire logic [7:0] dev_wdata,
   input wire logic dev_wr,
   input wire logic dev_rd,
   input wire logic sysref,
   output logic [7:0] dev_rdata,
   output logic aligned
);
   logic [7:0] sync_control, link_control, link_subclass, val;
   always_comb begin
      case (dev_addr)
         SLLSU_ADDR_SYNC_CTRL: val = sync_control;
         SLLSU_ADDR_LINK_CTRL: val = link_control;
         SLLSU_ADDR_SUBCLASS: val = link_subclass;
         SLLSU_ADDR_LAT0: val = LAT0;
         SLLSU_ADDR_LAT1: val = LAT1;
         default: val = 8'h00;
      endcase
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         sync_control <= 8'h00;
         link_control <= 8'h00;
         link_subclass <= 8'h00;
         aligned <= 1'b0;
         dev_rdata <= 8'h00;
      end else begin
         if (dev_wr && dev_addr == SLLSU_ADDR_SYNC_CTRL) begin
            sync_control <= dev_wdata;
         end
         if (dev_wr && dev_addr == SLLSU_ADDR_LINK_CTRL) begin
            link_control <= dev_wdata;
         end
         if (dev_wr && dev_addr == SLLSU_ADDR_SUBCLASS) begin
            link_subclass <= dev_wdata;
         end
         // reference only counts when armed in subclass 1
         if (sysref && sync_control == SLLSU_SYNC_ARM && link_subclass[0]) begin
            aligned <= 1'b1;
         end
         // released bus toggles so stale data never matches
         dev_rdata <= dev_rd ? val : ~dev_rdata;
      end
   end
endmodule

// *** testbench/sllsu_host_bench.sv ***
// bench: setup table, sync sequences, refusal and fault cases
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; $display("BAD %s exp %h got %h", n, e, g); end end
module sllsu_host_bench;
   import sllsu_pkg::*;
   typedef struct {logic [31:0] cfg; logic [15:0] rate; logic [15:0] dly; logic [15:0] phy; logic [15:0] lmfc;} sllsu_row_t;
   logic SYS_CLK = 1'b0;
   logic RST = 1'b1;
   logic [3:0] ADDR = 4'h0;
   logic [31:0] WDATA = 32'h0000_0000;
   logic WR = 1'b0;
   logic RD = 1'b0;
   logic [31:0] RDATA, d;
   logic [15:0] DEV_ADDR;
   logic [7:0] DEV_WDATA, DEV_RDATA;
   logic DEV_WR, DEV_RD, SYSREF_PULSE, aligned;
   logic [15:0] wa [0:31];
   logic [7:0] wd [0:31];
   int nw = 0, nref = 0, ref_at = 0, err_count = 0, total_checks = 0, k;
   sllsu_row_t rows [5] = '{
      '{32'h0000_6499, 16'h07D0, 16'h0805, 16'h40E7, 16'h0510},
      '{32'h0000_962A, 16'h1388, 16'h0A03, 16'h0015, 16'h0902},
      '{32'h0000_7796, 16'h2710, 16'h1514, 16'h4083, 16'h0306},
      '{32'h0000_7812, 16'h0C1C, 16'h0901, 16'h0060, 16'h0A00},
      '{32'h0000_32B4, 16'h1838, 16'h0909, 16'h0090, 16'h0200}};
   sllsu_host uut (.SYS_CLK(SYS_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
      .DEV_ADDR(DEV_ADDR), .DEV_WDATA(DEV_WDATA), .DEV_WR(DEV_WR), .DEV_RD(DEV_RD), .DEV_RDATA(DEV_RDATA),
      .SYSREF_PULSE(SYSREF_PULSE));
   sllsu_dev_model dev (.clk(SYS_CLK), .rst(RST), .dev_addr(DEV_ADDR), .dev_wdata(DEV_WDATA), .dev_wr(DEV_WR),
      .dev_rd(DEV_RD), .sysref(SYSREF_PULSE), .dev_rdata(DEV_RDATA), .aligned(aligned));
   initial begin
      forever #2.5 SYS_CLK = ~SYS_CLK;
   end
   always @(posedge SYS_CLK) begin
      if (DEV_WR) begin
         wa[nw] <= DEV_ADDR;
         wd[nw] <= DEV_WDATA;
         nw <= nw + 1;
      end
      if (SYSREF_PULSE) begin
         nref <= nref + 1;
         ref_at <= nw;
      end
   end
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge SYS_CLK);
      WR <= 1'b1;
      ADDR <= a;
      WDATA <= v;
      @(posedge SYS_CLK);
      WR <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge SYS_CLK);
      RD <= 1'b1;
      ADDR <= a;
      @(posedge SYS_CLK);
      RD <= 1'b0;
      #1;
      d = RDATA;
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic run_seq(input logic [31:0] c, input logic [7:0] lc, input int nr, input logic [15:0] mm);
      int b;
      int r;
      logic [7:0] sv [5];
      logic [15:0] sa [5];
      b = nw;
      r = nref;
      sv = '{{7'h00, c[7]}, SLLSU_SYNC_ONESHOT, SLLSU_SYNC_ENABLE, SLLSU_SYNC_ARM, lc};
      sa = '{SLLSU_ADDR_SUBCLASS, SLLSU_ADDR_SYNC_CTRL, SLLSU_ADDR_SYNC_CTRL, SLLSU_ADDR_SYNC_CTRL, SLLSU_ADDR_LINK_CTRL};
      wr(SLLSU_R_CFG, c);
      wr(SLLSU_R_CMD, 32'h0000_0003);
      wr(SLLSU_R_CFG, 32'h0000_0000);
      d = 32'hFFFF_FFFF;
      for (k = 0; k < 100 && d[0] !== 1'b0; k++) begin
         rd(SLLSU_R_STATUS);
      end
      if (d[0] !== 1'b0) begin
         err_count++;
         give_verdict();
      end
      `CHK("pooled", 1'b1, d[5])
      `CHK("writes", 5, nw - b)
      for (int i = 0; i < 5; i++) begin
         `CHK("wr addr", sa[i], wa[b + i])
         `CHK("wr data", sv[i], wd[b + i])
      end
      `CHK("ref count", nr, nref - r)
      if (nr > 0) begin
         `CHK("ref slot", b + 4, ref_at)
      end
      rd(SLLSU_R_CFG);
      `CHK("cfg kept", c, d)
      rd(SLLSU_R_LAT);
      `CHK("latency", 16'h0E06, d[15:0])
      rd(SLLSU_R_LATMM);
      `CHK("pool minmax", mm, d[15:0])
   endtask
   initial begin
      repeat (20) @(posedge SYS_CLK);
      RST <= 1'b0;
      foreach (rows[i]) begin
         wr(SLLSU_R_CFG, rows[i].cfg);
         wr(SLLSU_R_RATE, {16'h0000, rows[i].rate});
         wr(SLLSU_R_DELAY, {16'h0000, rows[i].dly});
         rd(SLLSU_R_PHY);
         `CHK("phy", rows[i].phy, d[15:0])
         rd(SLLSU_R_LMFC);
         `CHK("lmfc", rows[i].lmfc, d[15:0])
      end
      wr(SLLSU_R_DELAY, 32'h0000_0A01);
      rd(SLLSU_R_STATUS);
      `CHK("var limit", 1'b1, d[4])
      wr(SLLSU_R_DELAY, 32'h0000_0909);
      wr(SLLSU_R_CFG, 32'h0000_0000);
      rd(SLLSU_R_STATUS);
      `CHK("k16 mode", 1'b1, d[4])
      wr(SLLSU_R_CFG, 32'h0000_0010);
      rd(SLLSU_R_STATUS);
      `CHK("k32 mode", 1'b0, d[4])
      rd(4'hF);
      `CHK("unmapped", 32'h0000_0000, d)
      run_seq(32'h0001_00FA, 8'h4F, 1, 16'h160E);
      `CHK("aligned", 1'b1, aligned)
      run_seq(32'h0000_0017, 8'h01, 0, 16'h2E26);
      wr(SLLSU_R_CMD, 32'h0000_0001);
      repeat (4) @(posedge SYS_CLK);
      RST <= 1'b1;
      repeat (2) @(posedge SYS_CLK);
      RST <= 1'b0;
      rd(SLLSU_R_STATUS);
      `CHK("busy reset", 1'b0, d[0])
      give_verdict();
   end
endmodule
bind sllsu_host sllsu_host_asserts chk (.SYS_CLK(SYS_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
   .RD(RD), .RDATA(RDATA), .DEV_ADDR(DEV_ADDR), .DEV_WDATA(DEV_WDATA), .DEV_WR(DEV_WR), .DEV_RD(DEV_RD),
   .DEV_RDATA(DEV_RDATA), .SYSREF_PULSE(SYSREF_PULSE));
